// *** rtl/dsio_pkg.sv ***
// Package for the serial input/output port of the signal processor.
// Assumes a 10 MHz system clock; serial clocks are far slower.
package dsio_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned CNT_W         = 6;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Half period of the internal serial clock, in nanoseconds and then in system clock cycles.
  localparam int unsigned SCK_HALF_NS   = 400;
  localparam int unsigned SCK_HALF_CYC  =
    (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES   = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } dsio_word_t;

  typedef enum logic [1:0] {
    DSIO_IDLE = 2'b01,
    DSIO_BUSY = 2'b10
  } dsio_state_t;

endpackage

// *** rtl/dsio_port.sv ***
// Serial input and output port of a floating-point signal processor.
// Assumes a parallel word side on clock_i and slow serial pins outside.
// Behaviour
// - Receive bit sampled on falling receive clock.
// - Receive clock pin direction chosen by setting.
// - Receive only while receive enable is low.
// - Transmit data changes on rising clock edge.
// - Transmit data line floats when idle.
// - Transmit clock pin direction chosen by setting.
// - Transmit only while transmit enable is low.
// - Request high on load, low after shift-out.
`timescale 1ns/1ps
module dsio_port #(
  parameter int unsigned WORD_W = dsio_pkg::WORD_W
) (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                rx_clk_int_i,
  input  wire logic                tx_clk_int_i,
  input  wire logic                rx_shift_clock_i,
  output logic                     rx_shift_clock_o,
  output logic                     rx_shift_clock_oe_o,
  input  wire logic                rx_data_i,
  input  wire logic                rx_enable_n_i,
  output dsio_pkg::dsio_word_t     rx_word_o,
  input  wire logic                tx_clock_i,
  output logic                     tx_clock_o,
  output logic                     tx_clock_oe_o,
  output logic                     tx_data_o,
  output logic                     tx_data_oe_o,
  input  wire logic                tx_enable_n_i,
  input  dsio_pkg::dsio_word_t     tx_word_i,
  output logic                     tx_ready_o,
  output logic                     tx_request_o
);

  localparam logic [dsio_pkg::CNT_W-1:0] LAST_BIT =
    dsio_pkg::CNT_W'(WORD_W - 1);
  localparam logic [3:0] HALF = 4'(dsio_pkg::SCK_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rx_ck_lvl, rx_ck_rise, rx_ck_fall;
  logic tx_ck_lvl, tx_ck_rise, tx_ck_fall;
  logic rx_d_lvl, rx_en_lvl, tx_en_lvl;

  dsio_sync u_rx_ck (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (rx_shift_clock_i),
    .level_o (rx_ck_lvl),
    .rise_o  (rx_ck_rise),
    .fall_o  (rx_ck_fall)
  );
  dsio_sync u_tx_ck (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (tx_clock_i),
    .level_o (tx_ck_lvl),
    .rise_o  (tx_ck_rise),
    .fall_o  (tx_ck_fall)
  );
  dsio_sync u_rx_d (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (rx_data_i),
    .level_o (rx_d_lvl),
    .rise_o  (),
    .fall_o  ()
  );
  dsio_sync u_rx_en (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (rx_enable_n_i),
    .level_o (rx_en_lvl),
    .rise_o  (),
    .fall_o  ()
  );
  dsio_sync u_tx_en (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (tx_enable_n_i),
    .level_o (tx_en_lvl),
    .rise_o  (),
    .fall_o  ()
  );

  // ----------------------------------------------------------------
  // Internal serial clock generator
  // ----------------------------------------------------------------
  logic [3:0] div_cnt;
  logic       int_ck;
  logic       int_fall_d;
  wire        div_wrap = (div_cnt == HALF);
  wire        int_rise = div_wrap & ~int_ck;
  wire        int_fall = div_wrap & int_ck;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt    <= 4'h0;
      int_ck     <= 1'b0;
      int_fall_d <= 1'b0;
    end else begin
      div_cnt    <= div_wrap ? 4'h0 : div_cnt + 4'h1;
      int_fall_d <= int_fall;
      if (div_wrap) begin
        int_ck <= ~int_ck;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock pin direction and edge selection
  // ----------------------------------------------------------------
  // Driven clocks come from the divider flop; sensed ones are sampled.
  // The sensed data line trails its pin by the synchroniser, so a strobe
  // one cycle after a driven fall takes the bit that stood at that fall.
  // The same delay keeps the output line driven through its last fall.
  wire rx_fall = rx_clk_int_i ? int_fall_d : rx_ck_fall;
  wire tx_rise = tx_clk_int_i ? int_rise : tx_ck_rise;
  wire tx_fall = tx_clk_int_i ? int_fall_d : tx_ck_fall;
  wire rx_go   = rx_fall & ~rx_en_lvl;
  wire tx_en   = ~tx_en_lvl;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_shift_clock_o    <= 1'b0;
      rx_shift_clock_oe_o <= 1'b0;
      tx_clock_o          <= 1'b0;
      tx_clock_oe_o       <= 1'b0;
    end else begin
      rx_shift_clock_o    <= div_wrap ? ~int_ck : int_ck;
      rx_shift_clock_oe_o <= rx_clk_int_i;
      tx_clock_o          <= div_wrap ? ~int_ck : int_ck;
      tx_clock_oe_o       <= tx_clk_int_i;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic [WORD_W-1:0]          rx_shift;
  logic [dsio_pkg::CNT_W-1:0] rx_cnt;
  wire                        rx_last = (rx_cnt == LAST_BIT);
  wire [WORD_W-1:0]           next_rx_shift =
    {rx_shift[WORD_W-2:0], rx_d_lvl};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_shift  <= dsio_pkg::WORD_RST;
      rx_cnt    <= '0;
      rx_word_o <= '0;
    end else begin
      rx_word_o.valid <= 1'b0;
      if (rx_go) begin
        rx_shift <= next_rx_shift;
        rx_cnt   <= rx_last ? '0 : rx_cnt + 1'b1;
        if (rx_last) begin
          rx_word_o.valid <= 1'b1;
          rx_word_o.data  <= next_rx_shift;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // The request flag follows the busy state of the output shifter, which is held in tx_state.
  dsio_pkg::dsio_state_t      tx_state;
  logic [WORD_W-1:0]          tx_shift;
  logic [dsio_pkg::CNT_W-1:0] tx_cnt;
  logic                       tx_primed;
  wire tx_busy = (tx_state == dsio_pkg::DSIO_BUSY);
  wire tx_load = tx_word_i.valid & ~tx_busy;
  wire tx_step = tx_busy & tx_en & tx_rise;
  wire tx_done = tx_busy & tx_en & tx_fall & tx_primed &
                 (tx_cnt == LAST_BIT);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state     <= dsio_pkg::DSIO_IDLE;
      tx_shift     <= dsio_pkg::WORD_RST;
      tx_cnt       <= '0;
      tx_primed    <= 1'b0;
      tx_data_o    <= 1'b0;
      tx_data_oe_o <= 1'b0;
      tx_request_o <= 1'b0;
      tx_ready_o   <= 1'b0;
    end else begin
      tx_ready_o <= ~tx_busy & ~tx_load;
      case (tx_state)
        dsio_pkg::DSIO_IDLE: begin
          tx_data_oe_o <= 1'b0;
          if (tx_load) begin
            tx_shift     <= tx_word_i.data;
            tx_cnt       <= '0;
            tx_primed    <= 1'b0;
            tx_request_o <= 1'b1;
            tx_state     <= dsio_pkg::DSIO_BUSY;
          end
        end
        dsio_pkg::DSIO_BUSY: begin
          tx_data_oe_o <= tx_en & tx_primed;
          if (tx_step) begin
            tx_data_o <= tx_shift[WORD_W-1];
            tx_shift  <= {tx_shift[WORD_W-2:0], 1'b0};
            tx_data_oe_o <= 1'b1;
            if (tx_primed) begin
              tx_cnt <= tx_cnt + 1'b1;
            end
            tx_primed <= 1'b1;
          end
          if (tx_done) begin
            tx_request_o <= 1'b0;
            tx_data_oe_o <= 1'b0;
            tx_state     <= dsio_pkg::DSIO_IDLE;
          end
        end
        default: begin
          tx_state <= dsio_pkg::DSIO_IDLE;
        end
      endcase
    end
  end

endmodule

// *** rtl/dsio_sync.sv ***
// Three-stage synchroniser with edge detection for one serial pin.
// Assumes the pin is asynchronous to clock_i.
`timescale 1ns/1ps
module dsio_sync (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic s1;
  logic s2;
  logic s3;

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  // A change counts once the second and third stages agree.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end

  wire next_level = (s2 == s3) ? s3 : level_o;

  assign rise_o = next_level & ~level_o;
  assign fall_o = ~next_level & level_o;

endmodule

// *** test/dsio_far.sv ***
// Far-end codec model: sends and takes 32-bit words, MSB first.
// Assumes the bench resolves each clock pin from both drivers.
`timescale 1ns/1ps
module dsio_far (
  input  wire logic rx_ck_i,
  input  wire logic rx_en_n_i,
  input  wire logic tx_ck_i,
  input  wire logic tx_en_n_i,
  input  wire logic tx_dat_i,
  output logic      ck_o,
  output logic      rx_dat_o
);
  logic [31:0] rx_w = 32'h0;
  logic [31:0] tx_got = 32'h0;
  initial ck_o = 1'b0;
  initial rx_dat_o = 1'b0;
  // Bits move on the rise so each is steady across the fall.
  always @(posedge rx_ck_i) begin
    if (!rx_en_n_i) begin
      rx_dat_o <= rx_w[31];
      rx_w <= {rx_w[30:0], ~rx_w[0]};
    end
  end
  always @(negedge tx_ck_i) begin
    if (!tx_en_n_i) begin
      tx_got <= {tx_got[30:0], tx_dat_i};
    end
  end
  // The clock stands low between bursts; the offset keeps it off phase.
  task automatic burst(input int n);
    #37;
    repeat (n) begin
      #400 ck_o = 1'b1;
      #400 ck_o = 1'b0;
    end
  endtask
endmodule

// *** test/dsio_port_chk.sv ***
// Checker for dsio_port: direction, gating and request timing on pins.
// Assumes one clock domain with rst_i asynchronous and active high.
`timescale 1ns/1ps
module dsio_port_chk (
  input wire logic            clock_i,
  input wire logic            rst_i,
  input wire logic            rx_clk_int_i,
  input wire logic            tx_clk_int_i,
  input wire logic            rx_shift_clock_oe_o,
  input wire logic            rx_enable_n_i,
  input dsio_pkg::dsio_word_t rx_word_o,
  input wire logic            tx_clock_o,
  input wire logic            tx_clock_oe_o,
  input wire logic            tx_data_o,
  input wire logic            tx_data_oe_o,
  input wire logic            tx_enable_n_i,
  input dsio_pkg::dsio_word_t tx_word_i,
  input wire logic            tx_ready_o,
  input wire logic            tx_request_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  a_rx_clk_dir: assert property (
    $stable(rx_clk_int_i)[*4] |-> rx_shift_clock_oe_o == rx_clk_int_i)
    else $error("rx clock direction");
  a_tx_clk_dir: assert property (
    $stable(tx_clk_int_i)[*4] |-> tx_clock_oe_o == tx_clk_int_i)
    else $error("tx clock direction");
  a_tx_idle_float: assert property (
    !tx_request_o |-> !tx_data_oe_o)
    else $error("tx line driven while idle");
  a_tx_gate_off: assert property (
    tx_enable_n_i[*8] |-> !tx_data_oe_o)
    else $error("tx line driven while disabled");
  // A data change inside a word must land while the driven clock is high; a sensed clock is not checked.
  a_tx_rise_edge: assert property (
    $changed(tx_data_o) && tx_data_oe_o && $past(tx_data_oe_o)
    && tx_clock_oe_o |-> tx_clock_o)
    else $error("tx data moved off rising edge");
  a_tx_req_load: assert property (
    tx_word_i.valid && tx_ready_o |=> tx_request_o)
    else $error("request not raised on load");
  a_tx_freeze: assert property (
    tx_enable_n_i[*8] ##0 tx_request_o |=> tx_request_o)
    else $error("tx word ended while disabled");
  a_rx_gate_off: assert property (
    rx_enable_n_i[*8] |-> !rx_word_o.valid)
    else $error("rx word while disabled");
endmodule
bind dsio_port dsio_port_chk dsio_port_chk_inst (
  .clock_i(clock_i), .rst_i(rst_i), .rx_clk_int_i(rx_clk_int_i),
  .tx_clk_int_i(tx_clk_int_i), .rx_shift_clock_oe_o(rx_shift_clock_oe_o),
  .rx_enable_n_i(rx_enable_n_i), .rx_word_o(rx_word_o),
  .tx_clock_o(tx_clock_o), .tx_clock_oe_o(tx_clock_oe_o),
  .tx_data_o(tx_data_o), .tx_data_oe_o(tx_data_oe_o),
  .tx_enable_n_i(tx_enable_n_i), .tx_word_i(tx_word_i),
  .tx_ready_o(tx_ready_o), .tx_request_o(tx_request_o));

// *** test/test_dsio_port.sv ***
// Bench for dsio_port with the far-end model on its serial pins.
// Assumes dsio_far and the bound checker are compiled before it.
`timescale 1ns/1ps
module test_dsio_port;
  logic clock_i, rst_i, rx_clk_int_i, tx_clk_int_i, rx_enable_n_i;
  logic tx_enable_n_i, rx_shift_clock_o, rx_shift_clock_oe_o, tx_ready_o;
  logic tx_clock_o, tx_clock_oe_o, tx_data_o, tx_data_oe_o, tx_request_o;
  logic rx_data_i, ck;
  wire  rx_shift_clock_i, tx_clock_i, tx_line;
  dsio_pkg::dsio_word_t rx_word_o, tx_word_i;
  int miscompares = 0;
  int total_checks = 0;
  assign rx_shift_clock_i = rx_shift_clock_oe_o ? rx_shift_clock_o : ck;
  assign tx_clock_i = tx_clock_oe_o ? tx_clock_o : ck;
  assign tx_line = tx_data_oe_o ? tx_data_o : 1'bz;
  dsio_port dsio_port_inst (
    .clock_i(clock_i), .rst_i(rst_i),
    .rx_clk_int_i(rx_clk_int_i), .tx_clk_int_i(tx_clk_int_i),
    .rx_shift_clock_i(rx_shift_clock_i),
    .rx_shift_clock_o(rx_shift_clock_o),
    .rx_shift_clock_oe_o(rx_shift_clock_oe_o),
    .rx_data_i(rx_data_i), .rx_enable_n_i(rx_enable_n_i),
    .rx_word_o(rx_word_o), .tx_clock_i(tx_clock_i),
    .tx_clock_o(tx_clock_o), .tx_clock_oe_o(tx_clock_oe_o),
    .tx_data_o(tx_data_o), .tx_data_oe_o(tx_data_oe_o),
    .tx_enable_n_i(tx_enable_n_i), .tx_word_i(tx_word_i),
    .tx_ready_o(tx_ready_o), .tx_request_o(tx_request_o));
  dsio_far dsio_far_inst (
    .rx_ck_i(rx_shift_clock_i), .rx_en_n_i(rx_enable_n_i),
    .tx_ck_i(tx_clock_i), .tx_en_n_i(tx_enable_n_i), .tx_dat_i(tx_line),
    .ck_o(ck), .rx_dat_o(rx_data_i));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, s, e);
    end
  endtask
  task lim(input int k, input int n);
    if (k >= n) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wrx;
    int k;
    for (k = 0; k < 600 && rx_word_o.valid !== 1'b1; k++) @(negedge clock_i);
    lim(k, 600);
  endtask
  task automatic wdone;
    int k;
    for (k = 0; k < 600 && tx_request_o !== 1'b0; k++) @(negedge clock_i);
    lim(k, 600);
  endtask
  task automatic load(input logic [31:0] w);
    int k;
    for (k = 0; k < 50 && tx_ready_o !== 1'b1; k++) @(negedge clock_i);
    lim(k, 50);
    @(posedge clock_i);
    tx_word_i <= {1'b1, w};
    @(posedge clock_i);
    tx_word_i.valid <= 1'b0;
  endtask
  // Enables move well clear of serial edges, as the pins are synchronised.
  task automatic set_en(input logic rx_n, input logic tx_n);
    repeat (8) @(posedge clock_i);
    rx_enable_n_i <= rx_n;
    tx_enable_n_i <= tx_n;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic t_rx_ext;
    dsio_far_inst.rx_w = 32'hA5C30F81;
    set_en(1'b0, 1'b1);
    dsio_far_inst.burst(16);
    set_en(1'b1, 1'b1);
    dsio_far_inst.burst(4);
    set_en(1'b0, 1'b1);
    fork
      dsio_far_inst.burst(16);
      wrx();
    join
    chk(rx_word_o.data, 32'hA5C30F81);
    set_en(1'b1, 1'b1);
    $display("rx external done");
  endtask
  task automatic t_tx_ext;
    load(32'h9E174B2D);
    set_en(1'b1, 1'b0);
    dsio_far_inst.burst(16);
    set_en(1'b1, 1'b1);
    dsio_far_inst.burst(4);
    chk({31'h0, tx_request_o}, 32'h1);
    set_en(1'b1, 1'b0);
    dsio_far_inst.burst(16);
    wdone();
    chk(dsio_far_inst.tx_got, 32'h9E174B2D);
    set_en(1'b1, 1'b1);
    $display("tx external done");
  endtask
  task automatic t_int;
    int k;
    @(posedge clock_i);
    rx_clk_int_i <= 1'b1;
    tx_clk_int_i <= 1'b1;
    dsio_far_inst.rx_w = 32'h3C69D2E7;
    load(32'h5AF01E8B);
    for (k = 0; k < 20 && rx_shift_clock_o !== 1'b1; k++) @(negedge clock_i);
    lim(k, 20);
    for (k = 0; k < 20 && rx_shift_clock_o !== 1'b0; k++) @(negedge clock_i);
    lim(k, 20);
    @(posedge clock_i);
    rx_enable_n_i <= 1'b0;
    tx_enable_n_i <= 1'b0;
    fork
      begin
        wrx();
        chk(rx_word_o.data, 32'h3C69D2E7);
      end
      begin
        wdone();
        chk(dsio_far_inst.tx_got, 32'h5AF01E8B);
      end
    join
    $display("internal clocks done");
  endtask
  initial begin
    rst_i = 1'b1;
    rx_clk_int_i = 1'b0;
    tx_clk_int_i = 1'b0;
    rx_enable_n_i = 1'b1;
    tx_enable_n_i = 1'b1;
    tx_word_i = '0;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    t_rx_ext();
    t_tx_ext();
    t_int();
    close_out();
  end
endmodule
